// >>> logic/pwr_mon_pkg.sv
// Constants and types shared by the power monitor conversion sequencer.
// Assumes a 250 MHz core clock; registers sit on 32-bit Avalon-MM words.
package pwr_mon_pkg;

    localparam int unsigned CLK_MHZ            = 250;
    localparam int unsigned WAKE_TIME_US       = 40;
    localparam int unsigned WAKE_CYCLES        = WAKE_TIME_US * CLK_MHZ;
    localparam int unsigned SCL_TIMEOUT_MS     = 28;
    localparam int unsigned SCL_TIMEOUT_CYCLES =
        SCL_TIMEOUT_MS * 1000 * CLK_MHZ;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ACC_W  = 25;

    // Register indices; the byte address is four times the index
    localparam logic [2:0] IDX_CONFIG  = 3'h0;
    localparam logic [2:0] IDX_SHUNT   = 3'h1;
    localparam logic [2:0] IDX_BUS     = 3'h2;
    localparam logic [2:0] IDX_POWER   = 3'h3;
    localparam logic [2:0] IDX_CURRENT = 3'h4;
    localparam logic [2:0] IDX_CAL     = 3'h5;
    localparam logic [2:0] IDX_MASK    = 3'h6;

    localparam int unsigned MODE_LSB  = 0;
    localparam int unsigned AVG_LSB   = 3;
    localparam int unsigned READY_BIT = 3;
    localparam int unsigned BUS_MSB   = 15;

    localparam logic [15:0] CONFIG_RESET = 16'h0007;
    localparam logic [15:0] CAL_RESET    = 16'h0000;

    localparam logic [2:0] MODE_OFF       = 3'h0;
    localparam logic [2:0] MODE_TRIG_SH   = 3'h1;
    localparam logic [2:0] MODE_TRIG_BUS  = 3'h2;
    localparam logic [2:0] MODE_TRIG_BOTH = 3'h3;
    localparam logic [2:0] MODE_CONT_BOTH = 3'h7;

    localparam int unsigned CUR_SHIFT = 11;
    localparam int unsigned PWR_SHIFT = 13;

    typedef enum logic [2:0] {
        ST_OFF, ST_WAKE, ST_IDLE, ST_SHUNT, ST_BUS, ST_NEXT
    } state_t;

endpackage

// >>> logic/rst_release.sv
// Reset release: async assert, two-flop synchronous release.
// Assumes nrst_i may change at any time relative to core_clk_i.
`timescale 1ns/1ns
module rst_release (
    input  wire logic core_clk_i,   // Core clock
    input  wire logic nrst_i,       // Raw reset, active low
    output logic      rst_n_o       // Released reset, active low
);
    logic stage;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stage   <= 1'b0;
            rst_n_o <= 1'b0;
        end else begin
            stage   <= 1'b1;
            rst_n_o <= stage;
        end
    end
endmodule // rst_release

// >>> logic/scl_low_timeout.sv
// Serial clock low-time watchdog for the serial target port.
// Assumes scl_i is asynchronous to core_clk_i.
`timescale 1ns/1ns
module scl_low_timeout #(
    parameter int unsigned LIMIT = 1000
) (
    input  wire logic core_clk_i,   // Core clock
    input  wire logic rst_n_i,      // Synchronised reset, active low
    input  wire logic scl_i,        // Serial clock pin level
    output logic      timeout_o     // One-cycle serial port reset
);
    logic        scl_meta;
    logic        scl_sync;
    logic [31:0] low_cnt;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
        end else begin
            scl_meta <= scl_i;
            scl_sync <= scl_meta;
        end
    end

    // Counts low time, pulses once when the limit is passed
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_cnt   <= 32'h0;
            timeout_o <= 1'b0;
        end else if (scl_sync) begin
            low_cnt   <= 32'h0;
            timeout_o <= 1'b0;
        end else begin
            if (low_cnt <= LIMIT)
                low_cnt <= low_cnt + 32'h1;
            timeout_o <= (low_cnt == LIMIT);
        end
    end

    chk_timeout_pulse: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        timeout_o |-> $past(!scl_sync) && $past(!scl_sync, 2))
        else $error("serial reset without long low clock");
endmodule // scl_low_timeout

// >>> logic/pwr_mon_seq.sv
// Conversion sequencer, averaging and result registers of a power monitor.
// Assumes an external converter answering each request with a done pulse
// on core_clk_i, and an Avalon-MM master honouring waitrequest.
`timescale 1ns/1ns
module pwr_mon_seq
    import pwr_mon_pkg::*;
#(
    parameter int unsigned WAKE_CNT = pwr_mon_pkg::WAKE_CYCLES,
    parameter int unsigned SCL_CNT  = pwr_mon_pkg::SCL_TIMEOUT_CYCLES
) (
    input  wire logic                          core_clk_i,        // Clock
    input  wire logic                          nrst_i,            // Reset
    input  wire logic [pwr_mon_pkg::ADDR_W-1:0] avs_address_i,    // Byte addr
    input  wire logic                          avs_read_i,        // Read
    input  wire logic                          avs_write_i,       // Write
    input  wire logic [31:0]                   avs_writedata_i,   // Wr data
    input  wire logic [3:0]                    avs_byteenable_i,  // Lanes
    output logic      [31:0]                   avs_readdata_o,    // Rd data
    output logic                               avs_waitrequest_o, // Stall
    output logic                               adc_req_o,         // Convert
    output logic                               adc_chan_o,        // 1 = bus
    input  wire logic                          adc_done_i,        // Done
    input  wire logic [pwr_mon_pkg::DATA_W-1:0] adc_data_i,       // Sample
    input  wire logic                          scl_i,             // SCL pin
    output logic                               serial_reset_o,    // Timeout
    output logic                               powered_down_o,    // Off
    output logic                               conv_ready_o       // Ready
);
    import pwr_mon_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [15:0] calc_current(
        input logic [15:0] shunt, input logic [15:0] cal);
        logic signed [32:0] prod;
        prod = $signed(shunt) * $signed({1'b0, cal});
        prod = prod >>> CUR_SHIFT;
        return (cal == 16'h0000) ? 16'h0000 : prod[15:0];
    endfunction

    function automatic logic [15:0] calc_power(
        input logic [15:0] cur, input logic [15:0] bus,
        input logic [15:0] cal);
        logic [16:0] mag;
        logic [32:0] prod;
        mag  = cur[15] ? 17'(-$signed({cur[15], cur})) : {1'b0, cur};
        prod = mag * bus;
        prod = prod >> PWR_SHIFT;
        return (cal == 16'h0000) ? 16'h0000 : prod[15:0];
    endfunction

    function automatic logic [15:0] avg_div(
        input logic [ACC_W-1:0] acc, input logic [2:0] code);
        logic signed [ACC_W-1:0] q;
        q = $signed(acc) >>> code;
        return q[15:0];
    endfunction

    function automatic logic [15:0] lane_merge(
        input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset and serial watchdog

    logic rst_n;

    rst_release u_rst (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .rst_n_o    (rst_n)
    );

    scl_low_timeout #(.LIMIT(SCL_CNT)) u_scl (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n),
        .scl_i      (scl_i),
        .timeout_o  (serial_reset_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state, then accepted

    logic [15:0] config_reg;
    logic [15:0] cal_reg;
    logic [15:0] shunt_reg;
    logic [15:0] bus_reg;
    logic [15:0] current_reg;
    logic [15:0] power_reg;
    logic        ready_seen;
    logic        cfg_written;
    logic        set_ready;
    logic        bus_acc;
    logic        hit;
    logic [2:0]  idx;
    logic [2:0]  mode;
    logic [2:0]  avg_code;
    logic [2:0]  new_mode;
    logic        active;
    logic        shunt_en;
    logic        bus_en;

    assign idx      = avs_address_i[4:2];
    assign hit      = (avs_address_i[1:0] == 2'b00) && (idx <= IDX_MASK);
    assign bus_acc  = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    assign mode     = config_reg[MODE_LSB +: 3];
    assign avg_code = config_reg[AVG_LSB +: 3];
    assign active   = (mode[1:0] != 2'b00);
    assign shunt_en = mode[0];
    assign bus_en   = mode[1];
    assign new_mode = 3'(lane_merge(config_reg, avs_writedata_i,
                                    avs_byteenable_i) >> MODE_LSB);

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n)
            avs_waitrequest_o <= 1'b1;
        else if (!avs_waitrequest_o)
            avs_waitrequest_o <= 1'b1;
        else if (avs_read_i || avs_write_i)
            avs_waitrequest_o <= 1'b0;
    end

    // Read data captured while waitrequest falls; reads have no side effect
    // on the sequencer
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata_o <= 32'h0;
            ready_seen     <= 1'b0;
        end else if (avs_read_i && avs_waitrequest_o) begin
            ready_seen     <= conv_ready_o && hit && (idx == IDX_MASK);
            unique case (idx)
                IDX_CONFIG:  avs_readdata_o <= {16'h0, config_reg};
                IDX_SHUNT:   avs_readdata_o <= {16'h0, shunt_reg};
                IDX_BUS:     avs_readdata_o <= {16'h0, bus_reg};
                IDX_POWER:   avs_readdata_o <= {16'h0, power_reg};
                IDX_CURRENT: avs_readdata_o <= {16'h0, current_reg};
                IDX_CAL:     avs_readdata_o <= {16'h0, cal_reg};
                IDX_MASK:    avs_readdata_o <= 32'(conv_ready_o) << READY_BIT;
                default:     avs_readdata_o <= 32'h0;
            endcase
            if (!hit)
                avs_readdata_o <= 32'h0;
        end
    end

    // Writes act regardless of power state
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            config_reg  <= CONFIG_RESET;
            cal_reg     <= CAL_RESET;
            cfg_written <= 1'b0;
        end else begin
            cfg_written <= bus_acc && avs_write_i && hit
                           && (idx == IDX_CONFIG);
            if (bus_acc && avs_write_i && hit && idx == IDX_CONFIG)
                config_reg <= lane_merge(config_reg, avs_writedata_i,
                                         avs_byteenable_i);
            if (bus_acc && avs_write_i && hit && idx == IDX_CAL)
                cal_reg <= lane_merge(cal_reg, avs_writedata_i,
                                      avs_byteenable_i);
        end
    end

    // Ready flag: a set in the same cycle wins over any clear
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n)
            conv_ready_o <= 1'b0;
        else if (set_ready)
            conv_ready_o <= 1'b1;
        else if (bus_acc && avs_write_i && hit && idx == IDX_CONFIG
                 && new_mode[1:0] != 2'b00)
            conv_ready_o <= 1'b0;
        else if (bus_acc && avs_read_i && ready_seen)
            conv_ready_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    state_t      state;
    state_t      next_state;
    state_t      first_conv;
    logic        trig_pend;
    logic [31:0] wake_cnt;
    logic [7:0]  sample_cnt;
    logic        last_sample;
    logic        starting;
    logic        shunt_done;
    logic        bus_done;
    logic [15:0] bus_sample;
    logic [15:0] cur_calc;
    logic [15:0] cur_last;

    assign first_conv  = shunt_en ? ST_SHUNT : ST_BUS;
    assign last_sample = (sample_cnt == 8'((9'h1 << avg_code) - 9'h1));
    assign starting    = (state == ST_IDLE) && (next_state != ST_IDLE)
                         && (next_state != ST_OFF);
    assign shunt_done  = (state == ST_SHUNT) && adc_done_i && !cfg_written;
    assign bus_done    = (state == ST_BUS) && adc_done_i && !cfg_written;
    assign set_ready   = (state == ST_NEXT) && last_sample;
    assign bus_sample  = {1'b0, adc_data_i[BUS_MSB-1:0]};
    assign cur_calc    = calc_current(adc_data_i, cal_reg);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF:   if (active) next_state = ST_WAKE;
            ST_WAKE:  if (!active) next_state = ST_OFF;
                      else if (wake_cnt == 32'h0) next_state = ST_IDLE;
            ST_IDLE:  if (!active) next_state = ST_OFF;
                      else if (mode[2] || trig_pend)
                          next_state = first_conv;
            ST_SHUNT: if (cfg_written) next_state = ST_IDLE;
                      else if (adc_done_i)
                          next_state = bus_en ? ST_BUS : ST_NEXT;
            ST_BUS:   if (cfg_written) next_state = ST_IDLE;
                      else if (adc_done_i) next_state = ST_NEXT;
            ST_NEXT:  next_state = last_sample ? ST_IDLE : first_conv;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Recovery time after power-down
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n)
            wake_cnt <= 32'h0;
        else if (state == ST_OFF)
            wake_cnt <= 32'(WAKE_CNT - 1);
        else if (state == ST_WAKE && wake_cnt != 32'h0)
            wake_cnt <= wake_cnt - 32'h1;
    end

    // One set per triggered write; set wins over the start clear
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n)
            trig_pend <= 1'b0;
        else if (cfg_written)
            trig_pend <= !mode[2] && active;
        else if (starting)
            trig_pend <= 1'b0;
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            adc_req_o      <= 1'b0;
            adc_chan_o     <= 1'b0;
            powered_down_o <= 1'b0;
        end else begin
            adc_req_o      <= (next_state == ST_SHUNT)
                              || (next_state == ST_BUS);
            adc_chan_o     <= (next_state == ST_BUS);
            powered_down_o <= (next_state == ST_OFF)
                              || (next_state == ST_WAKE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulation, computed in the capture cycle

    logic [ACC_W-1:0] acc_shunt;
    logic [ACC_W-1:0] acc_bus;
    logic [ACC_W-1:0] acc_cur;
    logic [ACC_W-1:0] acc_pwr;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n)
            sample_cnt <= 8'h0;
        else if (starting)
            sample_cnt <= 8'h0;
        else if (state == ST_NEXT)
            sample_cnt <= sample_cnt + 8'h1;
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            acc_shunt <= '0;
            acc_cur   <= '0;
            cur_last  <= 16'h0;
        end else if (starting) begin
            acc_shunt <= '0;
            acc_cur   <= '0;
        end else if (shunt_done) begin
            acc_shunt <= acc_shunt + ACC_W'($signed(adc_data_i));
            acc_cur   <= acc_cur + ACC_W'($signed(cur_calc));
            cur_last  <= cur_calc;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            acc_bus <= '0;
            acc_pwr <= '0;
        end else if (starting) begin
            acc_bus <= '0;
            acc_pwr <= '0;
        end else if (bus_done) begin
            acc_bus <= acc_bus + ACC_W'(bus_sample);
            acc_pwr <= acc_pwr
                       + ACC_W'(calc_power(cur_last, bus_sample,
                                           cal_reg));
        end
    end

    // Outputs change only at the end of a full set
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            shunt_reg   <= 16'h0;
            current_reg <= 16'h0;
            bus_reg     <= 16'h0;
            power_reg   <= 16'h0;
        end else if (set_ready) begin
            if (shunt_en) begin
                shunt_reg   <= avg_div(acc_shunt, avg_code);
                current_reg <= avg_div(acc_cur, avg_code);
            end
            if (bus_en) begin
                bus_reg   <= avg_div(acc_bus, avg_code);
                power_reg <= avg_div(acc_pwr, avg_code);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    sequence seq_trig_write;
        cfg_written && !mode[2] && active && state == ST_IDLE;
    endsequence

    sequence seq_set_start;
        adc_req_o ##1 (adc_req_o && state == first_conv);
    endsequence

    chk_cont_loop: assert property (
        (state == ST_IDLE && mode == MODE_CONT_BOTH && !cfg_written)
        |=> state == ST_SHUNT ##1 adc_chan_o == 1'b0)
        else $error("continuous mode did not restart with shunt");
    chk_shunt_only: assert property (
        (shunt_done && !bus_en) |=> state == ST_NEXT && !adc_req_o)
        else $error("shunt-only mode converted bus");
    chk_current_calc: assert property (
        shunt_done |=> cur_last == $past(cur_calc))
        else $error("current not taken from the new shunt sample");
    chk_cal_zero: assert property (
        (shunt_done && cal_reg == 16'h0) |=> cur_last == 16'h0)
        else $error("current nonzero without calibration");
    chk_power_zero: assert property (
        (bus_done && cal_reg == 16'h0) |=> $stable(acc_pwr))
        else $error("power accumulated without calibration");
    chk_output_hold: assert property (
        !set_ready |=> $stable(shunt_reg) && $stable(power_reg))
        else $error("output changed outside a completed set");
    chk_read_quiet: assert property (
        (bus_acc && avs_read_i && state == ST_SHUNT && !adc_done_i)
        |=> state == ST_SHUNT && adc_req_o)
        else $error("read disturbed a conversion");
    chk_trig_start: assert property (
        seq_trig_write |-> ##[1:3] seq_set_start)
        else $error("triggered write did not start one set");
    chk_ready_cause: assert property (
        $rose(conv_ready_o) |-> $past(state) == ST_NEXT)
        else $error("ready set before the set completed");
    chk_ready_cfg: assert property (
        (cfg_written && active && !$past(set_ready)) |-> !conv_ready_o)
        else $error("configuration write left ready set");
    chk_bus_msb: assert property (
        bus_reg[BUS_MSB] == 1'b0)
        else $error("bus result exceeds full scale");
    chk_wake_wait: assert property (
        (state == ST_WAKE && wake_cnt != 32'h0) |=> state != ST_IDLE)
        else $error("measurement resumed before recovery time");
    chk_off_stays: assert property (
        (state == ST_OFF && !active) |=> state == ST_OFF)
        else $error("left power-down without an active mode");
endmodule // pwr_mon_seq

// >>> dv/adc_model.sv
// Converter model: answers each request with a one-cycle done pulse.
// Assumes requests are levels on the core clock; delay set by the bench.
`timescale 1ns/1ns
module adc_model (
    input  wire logic        clk_i,   // Core clock
    input  wire logic        req_i,   // Conversion wanted
    input  wire logic        chan_i,  // 1 = bus
    input  wire logic [2:0]  dly_i,   // Answer delay in cycles
    input  wire logic [15:0] sh_i,    // Shunt sample
    input  wire logic [15:0] bus_i,   // Bus sample
    output logic             done_o,  // Done pulse
    output logic [15:0]      data_o   // Sample
);
    logic [2:0] cnt = 3'h0;
    initial {done_o, data_o} = 17'h00000;
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        // Data is garbage outside the done cycle
        data_o <= ~data_o;
        if (req_i && !done_o) begin
            if (cnt == 3'h0) begin
                done_o <= 1'b1;
                data_o <= chan_i ? bus_i : sh_i;
                cnt    <= dly_i;
            end else begin
                cnt <= cnt - 3'h1;
            end
        end
    end
endmodule // adc_model

// >>> dv/testbench.sv
// Self-checking bench for the power monitor sequencer.
// Assumes pwr_mon_pkg and the converter model beside it.
`timescale 1ns/1ns
module testbench;
    import pwr_mon_pkg::*;
    logic clk = 0, nrst = 0, rd = 0, wr = 0, scl = 1, run = 1, dn;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [2:0] dly;
    logic [15:0] sh, bv, ob, cal, dat;
    logic wt, req, ch, srst, pd, rdy;
    int err_count = 0, cmp_count = 0, nsr = 0, n, seed = 32'h79d1409b;
    pwr_mon_seq #(.WAKE_CNT(8), .SCL_CNT(20)) pwr_mon_seq_inst (
        .core_clk_i(clk), .nrst_i(nrst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .adc_req_o(req), .adc_chan_o(ch),
        .adc_done_i(dn), .adc_data_i(dat), .scl_i(scl),
        .serial_reset_o(srst), .powered_down_o(pd), .conv_ready_o(rdy));
    adc_model adc_model_inst (.clk_i(clk), .req_i(req), .chan_i(ch),
        .dly_i(dly), .sh_i(sh), .bus_i(bv), .done_o(dn), .data_o(dat));
    initial forever #2 clk = ~clk;
    always #16 if (run) scl = ~scl;
    always @(posedge clk) if (srst) nsr <= nsr + 1;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [15:0] d);
        int k = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= {16'h0000, d};
        do begin @(posedge clk); k++; end while (wt && k < 40);
        q = rdat;
        if (k >= 40) begin
            err_count++;
            end_sim();
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wait_rdy();
        int k = 0;
        while (rdy !== 1'b1 && k < 900) begin @(posedge clk); k++; end
        chk(rdy, 1);
    endtask
    function automatic logic [15:0] cur_f(logic [15:0] s, logic [15:0] c);
        logic signed [31:0] p = $signed(s) * $signed({1'b0, c});
        return p[26:11];
    endfunction
    function automatic logic [15:0] pwr_f(logic [15:0] c, logic [15:0] b);
        logic [31:0] m = (c[15] ? 16'(16'h0 - c) : c) * b[14:0];
        return m[28:13];
    endfunction
    task automatic end_sim;
        if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        cal = 16'($random(seed)) & 16'h7FFF;
        sh = 16'($random(seed));
        bv = 16'($random(seed));
        dly = 3'($random(seed));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        bus(0, 5'h00, 0); chk(q, 32'h0007);
        bus(0, 5'h1C, 0); chk(q, 0);
        wait_rdy();
        bus(0, 5'h10, 0); chk(q, 0);
        bus(0, 5'h0C, 0); chk(q, 0);
        bus(0, 5'h08, 0); chk(q, {17'h0, bv[14:0]});
        bus(1, 5'h14, cal);
        bus(1, 5'h00, 16'h000B);
        @(posedge clk); chk(rdy, 0);
        wait_rdy();
        bus(0, 5'h04, 0); chk(q, {16'h0, sh});
        bus(0, 5'h10, 0); chk(q, {16'h0, cur_f(sh, cal)});
        bus(0, 5'h0C, 0); chk(q, pwr_f(cur_f(sh, cal), bv));
        bus(0, 5'h18, 0); chk(q[3], 1);
        @(posedge clk); chk(rdy, 0);
        repeat (60) @(posedge clk); chk({req, rdy}, 0);
        bus(1, 5'h00, 16'h000B);
        wait_rdy();
        ob = bv;
        bv <= 16'($random(seed));
        bus(1, 5'h00, 16'h0000);
        repeat (20) @(posedge clk); chk({pd, rdy, req}, 3'b110);
        bus(1, 5'h00, 16'h0001);
        n = 0;
        while (pd === 1'b1 && n < 99) begin @(posedge clk); n++; end
        chk(n >= 8 && n < 20, 1);
        wait_rdy();
        bus(0, 5'h08, 0); chk(q, {17'h0, ob[14:0]});
        chk(nsr, 0);
        wait (scl == 1'b0);
        run = 0;
        repeat (40) @(posedge clk); chk(nsr, 1);
        end_sim;
    end
    initial begin
        #100000;
        err_count++;
        end_sim;
    end
endmodule // testbench
